// [hdl/eai_pkg.sv]
package eai_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int IDX_W = 12;
  localparam int IDX_LSB = 2;
  localparam int DEC_TOP = IDX_W + IDX_LSB;
  localparam logic [IDX_W-1:0] STATUS_IDX = 12'hB02;
  localparam logic [IDX_W-1:0] ENABLE_IDX = 12'hB03;
  localparam logic [IDX_W-1:0] CLEAR_IDX = 12'hB05;
  localparam logic [IDX_W-1:0] FRAME_CTRL_IDX = 12'h10B;

  // ----------------------------------------------------------------
  // field layout, shared by status, enable and clear
  // ----------------------------------------------------------------
  localparam int REMOTE_STATE_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int MF_ALARM_BIT = 5;
  localparam int KEEP_ZERO_BIT = 4;
  localparam int LINE_CODE_BIT = 3;
  localparam int FRAME_LOSS_BIT = 2;
  localparam logic [7:0] ENABLE_WR_MASK = 8'h3C;
  localparam logic [7:0] EVENT_MASK = 8'h2C;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int FLC_W = 3;
  localparam logic [FLC_W-1:0] FLC_RESET = 3'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int REMOTE_ALARM_TIME_US = 375;
  localparam int REMOTE_ALARM_CYCLES =
    (REMOTE_ALARM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // axi answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // framer events, all on aclk
  // ----------------------------------------------------------------
  typedef struct packed {
    logic nas_strobe;
    logic a_bit;
    logic fas_strobe;
    logic fas_errored;
    logic mf_remote_alarm;
    logic line_code_error;
  } eai_rx_events_s;

  typedef enum logic [3:0] {
    RA_CLEAR = 4'h1,
    RA_CLEAR_ONE = 4'h2,
    RA_DECLARED = 4'h4,
    RA_DECLARED_ZERO = 4'h8
  } eai_remote_e;

  typedef enum logic [1:0] {
    FR_IN_FRAME = 2'h1,
    FR_OUT_OF_FRAME = 2'h2
  } eai_frame_e;

endpackage : eai_pkg

// [hdl/eai_remote_alarm.sv]
`timescale 1ns/1ps
module eai_remote_alarm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nas_strobe,
  input wire logic a_bit,
  output logic rx_remote_alarm_state
);

  eai_pkg::eai_remote_e state_reg;
  eai_pkg::eai_remote_e state_next;
  logic alarm_reg;
  logic alarm_next;

  // ----------------------------------------------------------------
  // two successive non-alignment frames decide either way
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (nas_strobe) begin
      unique case (state_reg)
        eai_pkg::RA_CLEAR: begin
          state_next = a_bit ? eai_pkg::RA_CLEAR_ONE : eai_pkg::RA_CLEAR;
        end
        eai_pkg::RA_CLEAR_ONE: begin
          state_next = a_bit ? eai_pkg::RA_DECLARED : eai_pkg::RA_CLEAR; // R1
        end
        eai_pkg::RA_DECLARED: begin
          state_next = a_bit ? eai_pkg::RA_DECLARED
                             : eai_pkg::RA_DECLARED_ZERO;
        end
        eai_pkg::RA_DECLARED_ZERO: begin
          state_next = a_bit ? eai_pkg::RA_DECLARED : eai_pkg::RA_CLEAR; // R2
        end
        default: begin
          state_next = eai_pkg::RA_CLEAR;
        end
      endcase
    end
    alarm_next = (state_next == eai_pkg::RA_DECLARED) ||
                 (state_next == eai_pkg::RA_DECLARED_ZERO);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= eai_pkg::RA_CLEAR;
      alarm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      alarm_reg <= alarm_next;
    end
  end

  assign rx_remote_alarm_state = alarm_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the last A bit seen pairs successive frames whatever the gap
  // between their strobes
  logic seen_reg;
  logic seen_next;
  logic last_a_reg;
  logic last_a_next;

  always_comb begin
    seen_next = seen_reg || nas_strobe;
    last_a_next = nas_strobe ? a_bit : last_a_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_reg <= 1'b0;
      last_a_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
      last_a_reg <= last_a_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence two_ones_s;
    nas_strobe && a_bit && seen_reg && last_a_reg;
  endsequence

  sequence two_zeros_s;
    nas_strobe && !a_bit && seen_reg && !last_a_reg;
  endsequence

  alarm_declare_a: assert property (two_ones_s |=> alarm_reg) // R1
    else $error("remote alarm not declared after two A=1 frames");

  alarm_clear_a: assert property (two_zeros_s |=> !alarm_reg) // R2
    else $error("remote alarm not cleared after two A=0 frames");

  alarm_single_a: assert property (!alarm_reg && // R1
    state_reg == eai_pkg::RA_CLEAR && nas_strobe |=> !alarm_reg)
    else $error("remote alarm declared after a single frame");

endmodule : eai_remote_alarm

// [hdl/eai_top.sv]
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Behaviour
// (R1) two successive non-alignment frames with A=1 declare the remote alarm
// (R2) two successive non-alignment frames with A=0 clear the remote alarm
// (R3) enable bit 7 reads the remote alarm state; writes ignored
// (R4) bit 5 enables the interrupt on multiframe alarm declare and clear
// (R5) software always writes zero to bit 4, which is stored
// (R6) bit 3 enables the interrupt on each line code violation
// (R7) bit 2 enables the interrupt on frame loss declare and clear
// (R8) bit 6 is reserved; writes ignored, reads zero
// (R9) enable register sits at index 0xB03
// (R10) status flags latch on events and clear when the status is read
// (R11) frame loss declared after programmed count of errored alignment words
// (R12) interrupt is high while any enabled status flag is set
module eai_top #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire eai_pkg::eai_rx_events_s rx_events,
  output logic rx_remote_alarm_state,
  output logic frame_loss_state,
  output logic irq
);

  if (ADDR_W < eai_pkg::DEC_TOP) begin : g_bad_addr_w
    $error("eai_top: ADDR_W too narrow for the register map");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SEL_NONE = 5'h01,
    SEL_STATUS = 5'h02,
    SEL_ENABLE = 5'h04,
    SEL_CLEAR = 5'h08,
    SEL_FRAME = 5'h10
  } eai_sel_e;

  function automatic eai_sel_e decode(input logic [ADDR_W-1:0] addr);
    logic [eai_pkg::IDX_W-1:0] idx;
    idx = addr[eai_pkg::DEC_TOP-1:eai_pkg::IDX_LSB];
    decode = SEL_NONE;
    if ((addr >> eai_pkg::DEC_TOP) == '0) begin
      if (idx == eai_pkg::STATUS_IDX) decode = SEL_STATUS;
      if (idx == eai_pkg::ENABLE_IDX) decode = SEL_ENABLE; // R9
      if (idx == eai_pkg::CLEAR_IDX) decode = SEL_CLEAR;
      if (idx == eai_pkg::FRAME_CTRL_IDX) decode = SEL_FRAME;
    end
  endfunction : decode

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wlane_reg, wlane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic wr_do;
  eai_sel_e wr_sel;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_sel = decode(awaddr_reg);

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (wr_do) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_sel == SEL_NONE) ? eai_pkg::RESP_SLVERR
                                        : eai_pkg::RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= eai_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] enable_reg, enable_next;
  logic [7:0] status_reg, status_next;
  logic [eai_pkg::FLC_W-1:0] flc_reg, flc_next;
  logic [7:0] events;
  logic [7:0] read_clr;
  logic [7:0] write_clr;
  logic wr_ok;
  logic rd_take;
  eai_sel_e rd_sel;

  assign wr_ok = wr_do && wlane_reg;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);
  // reading the status hands the flags over, so they drop together
  assign read_clr = (rd_take && rd_sel == SEL_STATUS) ? 8'hFF : 8'h00;
  assign write_clr = (wr_ok && wr_sel == SEL_CLEAR) ? wdata_reg : 8'h00;

  always_comb begin
    enable_next = enable_reg;
    flc_next = flc_reg;
    if (wr_ok && wr_sel == SEL_ENABLE) begin
      // bits 7 and 6 never store; bit 4 keeps what software wrote
      enable_next = wdata_reg & eai_pkg::ENABLE_WR_MASK; // R3 R5 R8
    end
    if (wr_ok && wr_sel == SEL_FRAME) begin
      flc_next = wdata_reg[eai_pkg::FLC_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    status_next = ((status_reg & ~(read_clr | write_clr)) | events) &
                  eai_pkg::EVENT_MASK; // R10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= eai_pkg::ENABLE_RESET;
      status_reg <= eai_pkg::STATUS_RESET;
      flc_reg <= eai_pkg::FLC_RESET;
    end else begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      flc_reg <= flc_next;
    end
  end

  assign irq = |(status_reg & enable_reg & eai_pkg::EVENT_MASK); // R12

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] enable_view;

  always_comb begin
    enable_view = enable_reg;
    enable_view[eai_pkg::REMOTE_STATE_BIT] = rx_remote_alarm_state; // R3
    enable_view[eai_pkg::RESERVED_BIT] = 1'b0; // R8
  end

  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next = eai_pkg::RESP_OKAY;
      unique case (rd_sel)
        SEL_STATUS: rdata_next = {24'h000000, status_reg};
        SEL_ENABLE: rdata_next = {24'h000000, enable_view};
        SEL_FRAME: rdata_next = {29'h0, flc_reg};
        SEL_CLEAR: rdata_next = 32'h00000000;
        SEL_NONE: begin
          rdata_next = 32'h00000000;
          rresp_next = eai_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= eai_pkg::RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // frame loss and event detection
  // ----------------------------------------------------------------
  eai_pkg::eai_frame_e frame_reg, frame_next;
  logic [eai_pkg::FLC_W-1:0] err_cnt_reg, err_cnt_next;
  logic [eai_pkg::FLC_W-1:0] threshold;
  logic mf_prev_reg;

  // a count of zero would never declare, so it acts as one
  assign threshold = (flc_reg == '0) ? eai_pkg::FLC_W'(1) : flc_reg;

  always_comb begin
    frame_next = frame_reg;
    err_cnt_next = err_cnt_reg;
    if (rx_events.fas_strobe) begin
      if (rx_events.fas_errored) begin
        if (err_cnt_reg != threshold) begin
          err_cnt_next = err_cnt_reg + eai_pkg::FLC_W'(1);
        end
        if (err_cnt_reg + eai_pkg::FLC_W'(1) == threshold) begin
          frame_next = eai_pkg::FR_OUT_OF_FRAME; // R11
        end
      end else begin
        err_cnt_next = '0;
        frame_next = eai_pkg::FR_IN_FRAME;
      end
    end
    events = 8'h00;
    events[eai_pkg::MF_ALARM_BIT] = rx_events.mf_remote_alarm != mf_prev_reg; // R4
    events[eai_pkg::LINE_CODE_BIT] = rx_events.line_code_error; // R6
    events[eai_pkg::FRAME_LOSS_BIT] = frame_next != frame_reg; // R7
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_reg <= eai_pkg::FR_IN_FRAME;
      err_cnt_reg <= '0;
      mf_prev_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      err_cnt_reg <= err_cnt_next;
      mf_prev_reg <= rx_events.mf_remote_alarm;
    end
  end

  assign frame_loss_state = frame_reg == eai_pkg::FR_OUT_OF_FRAME;

  eai_remote_alarm u_remote_alarm (
    .aclk(aclk),
    .aresetn(aresetn),
    .nas_strobe(rx_events.nas_strobe),
    .a_bit(rx_events.a_bit),
    .rx_remote_alarm_state(rx_remote_alarm_state)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  state_view_a: assert property (rd_take && rd_sel == SEL_ENABLE |=> // R3
    s_axi_rdata[eai_pkg::REMOTE_STATE_BIT] == $past(rx_remote_alarm_state))
    else $error("enable read does not show remote alarm state");

  reserved_zero_a: assert property (rvalid_reg |-> // R8
    !(enable_reg[eai_pkg::RESERVED_BIT] ||
      enable_reg[eai_pkg::REMOTE_STATE_BIT]))
    else $error("reserved or read-only enable bit stored");

  mf_irq_a: assert property (events[eai_pkg::MF_ALARM_BIT] && // R4
    enable_reg[eai_pkg::MF_ALARM_BIT] && !wr_ok |=> irq)
    else $error("multiframe alarm change missed the interrupt");

  lcv_irq_a: assert property (rx_events.line_code_error && // R6
    enable_reg[eai_pkg::LINE_CODE_BIT] && !wr_ok |=> irq [*1] ##0
    status_reg[eai_pkg::LINE_CODE_BIT])
    else $error("line code violation missed the interrupt");

  oof_irq_a: assert property ($changed(frame_reg) && // R7
    !$past(wr_ok) |-> status_reg[eai_pkg::FRAME_LOSS_BIT])
    else $error("frame loss change not latched");

  irq_level_a: assert property (irq == // R12
    |(status_reg & enable_reg & eai_pkg::EVENT_MASK))
    else $error("interrupt does not follow enabled flags");

  read_clear_a: assert property (rd_take && rd_sel == SEL_STATUS && // R10
    events == 8'h00 |=> status_reg == 8'h00 ##1
    !irq || $past(events) != 8'h00)
    else $error("status not cleared by read");

  set_wins_a: assert property (events[eai_pkg::LINE_CODE_BIT] |=> // R10
    status_reg[eai_pkg::LINE_CODE_BIT])
    else $error("event lost against a clear");

  oof_declare_a: assert property (rx_events.fas_strobe && // R11
    rx_events.fas_errored &&
    err_cnt_reg + eai_pkg::FLC_W'(1) == threshold |=> frame_loss_state)
    else $error("frame loss not declared at the programmed count");

  bresp_a: assert property (wr_do |=> s_axi_bvalid [*1] ##0 // R9
    (s_axi_bresp == eai_pkg::RESP_OKAY) == ($past(wr_sel) != SEL_NONE))
    else $error("write answer does not match decode");

endmodule : eai_top

// [verification/eai_line_model.sv]
`timescale 1ns/1ps
module eai_line_model #(
  parameter int GAP = 8
) (
  input wire logic aclk,
  output eai_pkg::eai_rx_events_s rx_events
);
  // ----
  // far-end line terminal, one strobe per frame word
  // ----
  // qualifiers flip once released, so a stale value never looks valid
  initial rx_events = '0;

  task automatic nas(input logic a);
    @(posedge aclk);
    rx_events.nas_strobe <= 1'b1;
    rx_events.a_bit <= a;
    @(posedge aclk);
    rx_events.nas_strobe <= 1'b0;
    rx_events.a_bit <= ~a;
    repeat (GAP) @(posedge aclk);
  endtask : nas

  task automatic fas(input logic err);
    @(posedge aclk);
    rx_events.fas_strobe <= 1'b1;
    rx_events.fas_errored <= err;
    @(posedge aclk);
    rx_events.fas_strobe <= 1'b0;
    rx_events.fas_errored <= ~err;
    repeat (GAP) @(posedge aclk);
  endtask : fas

  task automatic mf(input logic lvl);
    @(posedge aclk);
    rx_events.mf_remote_alarm <= lvl;
    repeat (GAP) @(posedge aclk);
  endtask : mf

  task automatic lcv();
    @(posedge aclk);
    rx_events.line_code_error <= 1'b1;
    @(posedge aclk);
    rx_events.line_code_error <= 1'b0;
    repeat (GAP) @(posedge aclk);
  endtask : lcv
endmodule : eai_line_model

// [verification/e1_alarm_interrupt_enable_test.sv]
`timescale 1ns/1ps
module e1_alarm_interrupt_enable_test;
  localparam logic [15:0] A_ST = {2'h0, eai_pkg::STATUS_IDX, 2'h0};
  localparam logic [15:0] A_EN = {2'h0, eai_pkg::ENABLE_IDX, 2'h0};
  localparam logic [15:0] A_CL = {2'h0, eai_pkg::CLEAR_IDX, 2'h0};
  localparam logic [15:0] A_FC = {2'h0, eai_pkg::FRAME_CTRL_IDX, 2'h0};
  logic aclk, aresetn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic rx_remote_alarm_state, frame_loss_state, irq;
  logic [7:0] d;
  logic [3:0] strb = 4'hF;
  eai_pkg::eai_rx_events_s rx_events;
  int error_cnt = 0;
  int n_compared = 0;

  eai_top u_eai_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_events, .rx_remote_alarm_state, .frame_loss_state,
    .irq
  );
  eai_line_model u_eai_line_model (.aclk, .rx_events);

  always #50 aclk = ~aclk;

  // ----
  // common tasks
  // ----
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic hang(input int n);
    if (n > 40) begin
      error_cnt++;
      $display("Error %0t: bus answer never came", $time);
      test_done();
    end
  endtask : hang

  // answers are sampled at the falling edge, where they have settled
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
      hang(n);
    end
  endtask : wr

  task automatic rd(input logic [15:0] a);
    logic ta, tr;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
      hang(n);
    end
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic expect_event(input logic [7:0] m);
    settle(1);
    check(irq, 1'b1);
    rd(A_ST);
    check(d, m);
    rd(A_ST);
    check(d, 8'h00);
    settle(1);
    check(irq, 1'b0);
  endtask : expect_event

  // ----
  // scenarios
  // ----
  task automatic test_regs();
    rd(A_EN);
    check(d, eai_pkg::ENABLE_RESET);
    check(r, eai_pkg::RESP_OKAY);
    rd(A_ST);
    check(d, 8'h00);
    wr(A_EN, 8'hEF);
    rd(A_EN);
    check(d, 8'h2C);
    wr(A_EN, 8'h28);
    rd(A_EN);
    check(d, 8'h28);
    strb = 4'hE;
    wr(A_EN, 8'h04);
    strb = 4'hF;
    check(r, eai_pkg::RESP_OKAY);
    rd(A_EN);
    check(d, 8'h28);
    wr(16'h6C0C, 8'h00);
    check(r, eai_pkg::RESP_SLVERR);
    rd(16'h2C10);
    check(r, eai_pkg::RESP_SLVERR);
    check(d, 8'h00);
    $display("test regs done");
  endtask : test_regs

  task automatic test_remote();
    u_eai_line_model.nas(1'b1);
    settle(1);
    check(rx_remote_alarm_state, 1'b0);
    u_eai_line_model.nas(1'b1);
    settle(1);
    check(rx_remote_alarm_state, 1'b1);
    wr(A_EN, 8'h2C);
    rd(A_EN);
    check(d, 8'hAC);
    u_eai_line_model.nas(1'b0);
    u_eai_line_model.nas(1'b1);
    u_eai_line_model.nas(1'b0);
    settle(1);
    check(rx_remote_alarm_state, 1'b1);
    u_eai_line_model.nas(1'b0);
    settle(1);
    check(rx_remote_alarm_state, 1'b0);
    $display("test remote done");
  endtask : test_remote

  task automatic test_events();
    u_eai_line_model.mf(1'b1);
    expect_event(8'h20);
    u_eai_line_model.mf(1'b0);
    expect_event(8'h20);
    u_eai_line_model.lcv();
    expect_event(8'h08);
    u_eai_line_model.fas(1'b1);
    u_eai_line_model.fas(1'b1);
    settle(1);
    check(frame_loss_state, 1'b0);
    check(irq, 1'b0);
    u_eai_line_model.fas(1'b1);
    check(frame_loss_state, 1'b1);
    expect_event(8'h04);
    u_eai_line_model.fas(1'b0);
    expect_event(8'h04);
    $display("test events done");
  endtask : test_events

  task automatic test_mask();
    wr(A_EN, 8'h00);
    u_eai_line_model.lcv();
    u_eai_line_model.mf(1'b1);
    settle(1);
    check(irq, 1'b0);
    wr(A_EN, 8'h08);
    settle(1);
    check(irq, 1'b1);
    wr(A_CL, 8'h08);
    settle(1);
    check(irq, 1'b0);
    rd(A_ST);
    check(d, 8'h20);
    u_eai_line_model.mf(1'b0);
    rd(A_ST);
    check(d, 8'h20);
    // violation and status read meet at one edge: the flag must survive
    fork
      u_eai_line_model.lcv();
      rd(A_ST);
    join
    check(d, 8'h00);
    rd(A_ST);
    check(d, 8'h08);
    $display("test mask done");
  endtask : test_mask

  task automatic test_count();
    wr(A_FC, 8'h01);
    wr(A_EN, 8'h04);
    u_eai_line_model.fas(1'b1);
    check(frame_loss_state, 1'b1);
    expect_event(8'h04);
    u_eai_line_model.fas(1'b0);
    expect_event(8'h04);
    $display("test count done");
  endtask : test_count

  task automatic test_reset();
    u_eai_line_model.lcv();
    wr(A_EN, 8'h08);
    settle(1);
    check(irq, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    check(irq, 1'b0);
    rd(A_EN);
    check(d, eai_pkg::ENABLE_RESET);
    rd(A_ST);
    check(d, eai_pkg::STATUS_RESET);
    rd(A_FC);
    check(d, {5'h00, eai_pkg::FLC_RESET});
    $display("test reset done");
  endtask : test_reset

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    check(irq, 1'b0);
    check(rx_remote_alarm_state, 1'b0);
    test_regs();
    test_remote();
    test_events();
    test_mask();
    test_count();
    test_reset();
    test_done();
  end
endmodule : e1_alarm_interrupt_enable_test
